// File: hdl/mwc_regs.sv
// Purpose: wakeup filter, wakeup control/status and checksum offload registers
// Assumes: event inputs come from logic on ref_clk, so they are not synchronised
// Notes: phy registers are never on the bus, only behind the management pair
`timescale 1ns/1ps
module mwc_regs (
   input wire logic ref_clk,
   input wire logic reset,
   input mwc_pkg::mwc_bus_req_t bus_req,
   output logic [mwc_pkg::DATA_W-1:0] rdata,
   input wire logic power_save,
   input wire logic rx_frame_done,
   input wire logic rx_dest_addr_bit0,
   input wire logic wake_frame_event,
   input wire logic wake_packet_event,
   output mwc_pkg::mwc_wake_t wake_ctrl,
   output logic wake_request,
   output mwc_pkg::mwc_filter_bank_t filter_words,
   output mwc_pkg::mwc_offload_t offload_ctrl,
   output logic [15:0] phy_control,
   output logic phy_soft_reset
);
   import mwc_pkg::*;

   // decoded strobes
   logic filter_wr;
   logic filter_rd;
   logic wake_wr;
   logic offload_wr;
   logic access_wr;

   // register state
   logic global_unicast_wake_enable_reg;
   logic wake_frame_enable_reg;
   logic wake_packet_enable_reg;
   logic wake_frame_received_reg;
   logic wake_packet_received_reg;
   logic wake_request_reg;
   logic tx_checksum_enable_reg;
   logic rx_checksum_start_mode_reg;
   logic rx_checksum_enable_reg;
   logic [PHY_IDX_W-1:0] mgmt_index_reg;
   logic mgmt_write_reg;
   logic [15:0] mgmt_data_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;

   // event terms
   logic frame_set;
   logic packet_set;
   logic unicast_hit;
   logic frame_clear;
   logic packet_clear;

   // sub-block wires
   logic [DATA_W-1:0] filter_rd_word;
   logic [PTR_W-1:0] filter_wr_ptr;
   logic [PTR_W-1:0] filter_rd_ptr;
   logic [PHY_IDX_W-1:0] phy_index;
   logic phy_wr;
   logic [15:0] phy_rdata;

   always_comb begin
      filter_wr = 1'b0;
      filter_rd = 1'b0;
      wake_wr = 1'b0;
      offload_wr = 1'b0;
      access_wr = 1'b0;
      if (bus_req.addr == FILTER_OFS) begin
         filter_wr = bus_req.wr;
         filter_rd = bus_req.rd;
      end else if (bus_req.addr == WAKE_OFS) begin
         wake_wr = bus_req.wr;
      end else if (bus_req.addr == OFFLOAD_OFS) begin
         offload_wr = bus_req.wr;
      end else if (bus_req.addr == MGMT_ACCESS_OFS) begin
         access_wr = bus_req.wr;
      end
   end

   mwc_filter_store u_filter (
      .ref_clk(ref_clk),
      .reset(reset),
      .wr_en(filter_wr),
      .wdata(bus_req.wdata),
      .rd_en(filter_rd),
      .rd_word(filter_rd_word),
      .filter_words(filter_words),
      .wr_ptr(filter_wr_ptr),
      .rd_ptr(filter_rd_ptr)
   );

   // wakeup control bits, only the documented positions are stored
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         global_unicast_wake_enable_reg <= 1'b0;
         wake_frame_enable_reg <= 1'b0;
         wake_packet_enable_reg <= 1'b0;
      end else if (wake_wr) begin
         global_unicast_wake_enable_reg <= bus_req.wdata[UNICAST_EN_BIT];
         wake_frame_enable_reg <= bus_req.wdata[WFE_BIT];
         wake_packet_enable_reg <= bus_req.wdata[WPE_BIT];
      end
   end

   // detection is gated by the enables so a stale flag never appears
   assign frame_set = wake_frame_event && wake_frame_enable_reg;
   assign packet_set = wake_packet_event && wake_packet_enable_reg;
   assign unicast_hit = rx_frame_done && !rx_dest_addr_bit0 && global_unicast_wake_enable_reg;
   assign frame_clear = wake_wr && bus_req.wdata[WFR_BIT];
   assign packet_clear = wake_wr && bus_req.wdata[WPR_BIT];

   // set wins over a clear in the same cycle
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wake_frame_received_reg <= 1'b0;
      end else begin
         wake_frame_received_reg <= frame_set
            || (wake_frame_received_reg && !frame_clear);
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wake_packet_received_reg <= 1'b0;
      end else begin
         wake_packet_received_reg <= packet_set
            || (wake_packet_received_reg && !packet_clear);
      end
   end

   // wake request is a one-cycle pulse, only meaningful while power saving
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wake_request_reg <= 1'b0;
      end else begin
         wake_request_reg <= power_save && (unicast_hit || frame_set || packet_set);
      end
   end

   // offload controls; safe-change timing is left to software
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tx_checksum_enable_reg <= 1'b0;
         rx_checksum_start_mode_reg <= 1'b0;
         rx_checksum_enable_reg <= 1'b0;
      end else if (offload_wr) begin
         tx_checksum_enable_reg <= bus_req.wdata[TXEN_BIT];
         rx_checksum_start_mode_reg <= bus_req.wdata[RXMODE_BIT];
         rx_checksum_enable_reg <= bus_req.wdata[RXEN_BIT];
      end
   end

   // management access: writing the access register launches the phy cycle
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mgmt_index_reg <= MGMT_ACCESS_RST[MGMT_IDX_LSB +: PHY_IDX_W];
         mgmt_write_reg <= MGMT_ACCESS_RST[MGMT_WRITE_BIT];
      end else if (access_wr) begin
         mgmt_index_reg <= bus_req.wdata[MGMT_IDX_LSB +: PHY_IDX_W];
         mgmt_write_reg <= bus_req.wdata[MGMT_WRITE_BIT];
      end
   end

   // a read access loads the data register; a bus write preloads it
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mgmt_data_reg <= MGMT_DATA_RST;
      end else if (bus_req.wr && bus_req.addr == MGMT_DATA_OFS) begin
         mgmt_data_reg <= bus_req.wdata[15:0];
      end else if (access_wr && !bus_req.wdata[MGMT_WRITE_BIT]) begin
         mgmt_data_reg <= phy_rdata;
      end
   end

   assign phy_index = bus_req.wdata[MGMT_IDX_LSB +: PHY_IDX_W];
   assign phy_wr = access_wr && bus_req.wdata[MGMT_WRITE_BIT];

   mwc_phy_index u_phy (
      .ref_clk(ref_clk),
      .reset(reset),
      .wr_en(phy_wr),
      .index(phy_index),
      .wdata(mgmt_data_reg),
      .rdata(phy_rdata),
      .phy_control(phy_control),
      .soft_reset_pulse(phy_soft_reset)
   );

   // read mux; reserved and unmapped read as zero
   always_comb begin
      rdata_next = '0;
      if (bus_req.rd) begin
         if (bus_req.addr == FILTER_OFS) begin
            rdata_next = filter_rd_word;
         end else if (bus_req.addr == WAKE_OFS) begin
            rdata_next[UNICAST_EN_BIT] = global_unicast_wake_enable_reg;
            rdata_next[WFR_BIT] = wake_frame_received_reg;
            rdata_next[WPR_BIT] = wake_packet_received_reg;
            rdata_next[WFE_BIT] = wake_frame_enable_reg;
            rdata_next[WPE_BIT] = wake_packet_enable_reg;
         end else if (bus_req.addr == OFFLOAD_OFS) begin
            rdata_next[TXEN_BIT] = tx_checksum_enable_reg;
            rdata_next[RXMODE_BIT] = rx_checksum_start_mode_reg;
            rdata_next[RXEN_BIT] = rx_checksum_enable_reg;
         end else if (bus_req.addr == MGMT_ACCESS_OFS) begin
            rdata_next[MGMT_IDX_LSB +: PHY_IDX_W] = mgmt_index_reg;
            rdata_next[MGMT_WRITE_BIT] = mgmt_write_reg;
         end else if (bus_req.addr == MGMT_DATA_OFS) begin
            rdata_next[15:0] = mgmt_data_reg;
         end
      end
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;
   assign wake_request = wake_request_reg;
   assign wake_ctrl.global_unicast_wake_enable = global_unicast_wake_enable_reg;
   assign wake_ctrl.wake_frame_enable = wake_frame_enable_reg;
   assign wake_ctrl.wake_packet_enable = wake_packet_enable_reg;
   assign offload_ctrl.tx_checksum_enable = tx_checksum_enable_reg;
   assign offload_ctrl.rx_checksum_start_mode = rx_checksum_start_mode_reg;
   assign offload_ctrl.rx_checksum_enable = rx_checksum_enable_reg;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence s_last_filter_write;
      filter_wr && filter_wr_ptr == PTR_LAST;
   endsequence

   sequence s_phy_soft_reset_write;
      phy_wr && phy_index == PHY_BCR_IDX && mgmt_data_reg[PHY_SOFT_RESET_BIT];
   endsequence

   AST_FILTER_WRITE_LANDS: assert property (
      filter_wr |=> filter_words[$past(filter_wr_ptr)] == $past(bus_req.wdata))
      else $error("filter write did not land at the write pointer");

   AST_FILTER_WRAP: assert property (s_last_filter_write |=> filter_wr_ptr == PTR_RST)
      else $error("filter write pointer did not wrap to zero");

   AST_FILTER_READ_STEP: assert property (
      filter_rd |=> filter_rd_ptr == $past(filter_rd_ptr) + 3'h1
         && rdata == filter_words[$past(filter_rd_ptr)])
      else $error("filter read did not return the word and advance");

   AST_UNICAST_WAKE: assert property (
      power_save && rx_frame_done && !rx_dest_addr_bit0 && global_unicast_wake_enable_reg
         |=> wake_request)
      else $error("unicast frame did not raise wake request");

   AST_FRAME_FLAG_STICKY: assert property (
      frame_set ##1 (!frame_clear)[*3] |=> wake_frame_received_reg)
      else $error("frame received flag lost without a clear");

   AST_PACKET_FLAG_CLEAR: assert property (
      wake_packet_received_reg && packet_clear && !packet_set |=> !wake_packet_received_reg)
      else $error("packet received flag not cleared by write");

   AST_FRAME_GATED: assert property (!wake_frame_enable_reg && !wake_frame_received_reg
      |=> !wake_frame_received_reg)
      else $error("frame flag set while detection disabled");

   AST_PACKET_SET: assert property (packet_set |=> wake_packet_received_reg)
      else $error("wake packet did not set its flag");

   AST_OFFLOAD_WRITE: assert property (
      offload_wr |=> offload_ctrl == {$past(bus_req.wdata[TXEN_BIT]),
         $past(bus_req.wdata[RXMODE_BIT]), $past(bus_req.wdata[RXEN_BIT])})
      else $error("offload controls do not follow the write");

   AST_RESERVED_ZERO: assert property (
      bus_req.rd && bus_req.addr == WAKE_OFS |=> (rdata & ~WAKE_READ_MASK) == '0)
      else $error("reserved wakeup bits read non-zero");

   AST_PHY_SOFT_RESET: assert property (
      s_phy_soft_reset_write |=> phy_soft_reset ##1 !phy_control[PHY_SOFT_RESET_BIT])
      else $error("phy soft reset bit did not clear itself");

   AST_PHY_HOLE_READ: assert property (
      access_wr && !bus_req.wdata[MGMT_WRITE_BIT] && !PHY_MAP[phy_index]
         |=> mgmt_data_reg == 16'h0000)
      else $error("unmapped phy index read non-zero");

   AST_FILTER_WRITE_STEP: assert property (
      filter_wr |=> filter_wr_ptr == $past(filter_wr_ptr) + 3'h1)
      else $error("filter write pointer did not advance");

   AST_FRAME_SET_WINS: assert property (
      frame_set && frame_clear |=> wake_frame_received_reg)
      else $error("frame flag clear won over a new frame");

   AST_PACKET_SET_WINS: assert property (
      packet_set && packet_clear |=> wake_packet_received_reg)
      else $error("packet flag clear won over a new packet");

   AST_PACKET_GATED: assert property (
      !wake_packet_enable_reg && !wake_packet_received_reg |=> !wake_packet_received_reg)
      else $error("packet flag set while detection disabled");

   AST_WAKE_NEEDS_POWER_SAVE: assert property (!power_save |=> !wake_request)
      else $error("wake request raised outside power saving");

   AST_OFFLOAD_RESERVED_ZERO: assert property (
      bus_req.rd && bus_req.addr == OFFLOAD_OFS |=> (rdata & ~OFFLOAD_READ_MASK) == '0)
      else $error("reserved offload bits read non-zero");
endmodule

// File: pkg/mwc_pkg.sv
// Purpose: shared constants and types for the wakeup and checksum register block
// Assumes: 8-bit byte addresses, 32-bit register words
// Notes: mgmt access/data offsets and phy reset values are local choices
package mwc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // register byte offsets
   localparam logic [7:0] FILTER_OFS = 8'ha8;
   localparam logic [7:0] WAKE_OFS = 8'hac;
   localparam logic [7:0] OFFLOAD_OFS = 8'hb0;
   localparam logic [7:0] MGMT_ACCESS_OFS = 8'hb4;
   localparam logic [7:0] MGMT_DATA_OFS = 8'hb8;

   // filter store
   localparam int FILTER_WORDS = 8;
   localparam int PTR_W = 3;
   localparam logic [PTR_W-1:0] PTR_LAST = 3'h7;
   localparam logic [PTR_W-1:0] PTR_RST = 3'h0;
   localparam logic [31:0] FILTER_RST = 32'h0000_0000;

   // wakeup control and status fields
   localparam int UNICAST_EN_BIT = 9;
   localparam int WFR_BIT = 6;
   localparam int WPR_BIT = 5;
   localparam int WFE_BIT = 2;
   localparam int WPE_BIT = 1;
   localparam logic [31:0] WAKE_READ_MASK = 32'h0000_0266;

   // checksum offload fields
   localparam int TXEN_BIT = 16;
   localparam int RXMODE_BIT = 1;
   localparam int RXEN_BIT = 0;
   localparam logic [31:0] OFFLOAD_READ_MASK = 32'h0001_0003;

   // management access register fields
   localparam int MGMT_IDX_LSB = 6;
   localparam int MGMT_WRITE_BIT = 1;
   localparam logic [31:0] MGMT_ACCESS_MASK = 32'h0000_07c2;
   localparam logic [31:0] MGMT_ACCESS_RST = 32'h0000_0000;
   localparam logic [15:0] MGMT_DATA_RST = 16'h0000;

   // phy register map, indexed 0..31
   localparam int PHY_IDX_W = 5;
   localparam int PHY_REGS = 32;
   localparam logic [31:0] PHY_MAP = 32'he806_007f;
   localparam logic [31:0] PHY_KEPT_MASK = 32'h0004_0000;
   localparam logic [4:0] PHY_BCR_IDX = 5'h00;
   localparam int PHY_SOFT_RESET_BIT = 15;
   localparam logic [15:0] PHY_BCR_RST = 16'h3000;
   localparam logic [15:0] PHY_REG_RST = 16'h0000;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } mwc_bus_req_t;

   typedef struct packed {
      logic tx_checksum_enable;
      logic rx_checksum_start_mode;
      logic rx_checksum_enable;
   } mwc_offload_t;

   typedef struct packed {
      logic global_unicast_wake_enable;
      logic wake_frame_enable;
      logic wake_packet_enable;
   } mwc_wake_t;

   typedef logic [FILTER_WORDS-1:0][DATA_W-1:0] mwc_filter_bank_t;
endpackage

// File: hdl/mwc_filter_store.sv
// Purpose: eight-word wakeup filter store behind one register window
// Assumes: write and read strobes are one cycle each
// Notes: separate read and write pointers, both wrap after the last word
`timescale 1ns/1ps
module mwc_filter_store (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [mwc_pkg::DATA_W-1:0] wdata,
   input wire logic rd_en,
   output logic [mwc_pkg::DATA_W-1:0] rd_word,
   output mwc_pkg::mwc_filter_bank_t filter_words,
   output logic [mwc_pkg::PTR_W-1:0] wr_ptr,
   output logic [mwc_pkg::PTR_W-1:0] rd_ptr
);
   import mwc_pkg::*;

   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;

   // pointer wraps naturally at 3 bits
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wr_ptr_reg <= PTR_RST;
      end else if (wr_en) begin
         wr_ptr_reg <= wr_ptr_reg + 3'h1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rd_ptr_reg <= PTR_RST;
      end else if (rd_en) begin
         rd_ptr_reg <= rd_ptr_reg + 3'h1;
      end
   end

   genvar i;
   generate
      for (i = 0; i < FILTER_WORDS; i = i + 1) begin : g_word
         always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
               filter_words[i] <= FILTER_RST;
            end else if (wr_en && wr_ptr_reg == PTR_W'(i)) begin
               filter_words[i] <= wdata;
            end
         end
      end
   endgenerate

   assign rd_word = filter_words[rd_ptr_reg];
   assign wr_ptr = wr_ptr_reg;
   assign rd_ptr = rd_ptr_reg;
endmodule

// File: hdl/mwc_phy_index.sv
// Purpose: phy register set reached only by a 5-bit index
// Assumes: one access per cycle from the management registers
// Notes: soft reset takes effect the cycle after the bit is written
`timescale 1ns/1ps
module mwc_phy_index (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [mwc_pkg::PHY_IDX_W-1:0] index,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata,
   output logic [15:0] phy_control,
   output logic soft_reset_pulse
);
   import mwc_pkg::*;

   logic [PHY_REGS-1:0][15:0] store_reg;
   logic soft_reset_reg;

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         soft_reset_reg <= 1'b0;
      end else begin
         soft_reset_reg <= wr_en && index == PHY_BCR_IDX && wdata[PHY_SOFT_RESET_BIT];
      end
   end

   genvar i;
   generate
      for (i = 0; i < PHY_REGS; i = i + 1) begin : g_reg
         localparam logic [15:0] RST_VAL = (i == 0) ? PHY_BCR_RST : PHY_REG_RST;
         if (PHY_MAP[i]) begin : g_mapped
            always_ff @(posedge ref_clk or posedge reset) begin
               if (reset) begin
                  store_reg[i] <= RST_VAL;
               end else if (soft_reset_reg && !PHY_KEPT_MASK[i]) begin
                  store_reg[i] <= RST_VAL;
               end else if (wr_en && index == PHY_IDX_W'(i)) begin
                  store_reg[i] <= wdata;
               end
            end
         end else begin : g_hole
            assign store_reg[i] = 16'h0000;
         end
      end
   endgenerate

   assign rdata = store_reg[index];
   assign phy_control = store_reg[0];
   assign soft_reset_pulse = soft_reset_reg;
endmodule

// File: verif/mwc_regs_test.sv
// Purpose: self-checking bench for the wakeup, filter, offload and phy index registers
// Assumes: one 40 MHz clock, bus requests launched just after rising edges
// Notes: fixed-seed random traffic plus reset, wrap and unmapped corner cases
`timescale 1ns/1ps
module mwc_regs_test;
   import mwc_pkg::*;
   logic ref_clk;
   logic reset;
   mwc_bus_req_t bus_req;
   logic [31:0] rdata;
   logic power_save;
   logic rx_frame_done;
   logic rx_dest_addr_bit0;
   logic wake_frame_event;
   logic wake_packet_event;
   mwc_wake_t wake_ctrl;
   logic wake_request;
   mwc_filter_bank_t filter_words;
   mwc_offload_t offload_ctrl;
   logic [15:0] phy_control;
   logic phy_soft_reset;
   int bad_count = 0;
   int samples_checked = 0;
   int seed = 32'h21eeb78a;
   logic en9, en2, en1, f6, f5;
   logic [31:0] fw [8];
   logic [15:0] pv [32];
   logic [31:0] d;
   logic [31:0] q;

   mwc_regs dut_u (
      .ref_clk(ref_clk),
      .reset(reset),
      .bus_req(bus_req),
      .rdata(rdata),
      .power_save(power_save),
      .rx_frame_done(rx_frame_done),
      .rx_dest_addr_bit0(rx_dest_addr_bit0),
      .wake_frame_event(wake_frame_event),
      .wake_packet_event(wake_packet_event),
      .wake_ctrl(wake_ctrl),
      .wake_request(wake_request),
      .filter_words(filter_words),
      .offload_ctrl(offload_ctrl),
      .phy_control(phy_control),
      .phy_soft_reset(phy_soft_reset)
   );

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   task summarize;
      $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      bus_req.addr <= a;
      bus_req.wdata <= v;
      bus_req.wr <= 1'b1;
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
      // registered outputs settle after the edge that takes the write
      @(negedge ref_clk);
   endtask

   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      @(negedge ref_clk);
      v = rdata;
   endtask

   function automatic logic [31:0] wake_exp();
      return {22'h0, en9, 2'b00, f6, f5, 2'b00, en2, en1, 1'b0};
   endfunction

   function automatic logic phy_mapped(input int i);
      return (i <= 6) || (i == 17) || (i == 18) || (i == 27) || (i >= 29);
   endfunction

   // data register first, then the access word with the write bit
   task phy_wr(input int i, input logic [15:0] v);
      wr(MGMT_DATA_OFS, {16'h0, v});
      wr(MGMT_ACCESS_OFS, (32'(i) << MGMT_IDX_LSB) | 32'h2);
   endtask

   task phy_rd(input int i, output logic [31:0] v);
      wr(MGMT_ACCESS_OFS, 32'(i) << MGMT_IDX_LSB);
      rd(MGMT_DATA_OFS, v);
   endtask

   // k: 0 frame match, 1 wake packet, 2 unicast frame, 3 group frame
   task ev(input int k, input logic ps);
      logic req;
      req = ps & ((k == 0 & en2) | (k == 1 & en1) | (k == 2 & en9));
      @(posedge ref_clk);
      power_save <= ps;
      wake_frame_event <= (k == 0);
      wake_packet_event <= (k == 1);
      rx_frame_done <= (k >= 2);
      rx_dest_addr_bit0 <= (k == 3);
      @(posedge ref_clk);
      wake_frame_event <= 1'b0;
      wake_packet_event <= 1'b0;
      rx_frame_done <= 1'b0;
      rx_dest_addr_bit0 <= ~rx_dest_addr_bit0;
      @(negedge ref_clk);
      chk("wake_request", {31'h0, req}, {31'h0, wake_request});
      if (k == 0 && en2) f6 = 1'b1;
      if (k == 1 && en1) f5 = 1'b1;
   endtask

   task wake_write(input logic [31:0] v);
      wr(WAKE_OFS, v);
      en9 = v[9];
      en2 = v[2];
      en1 = v[1];
      if (v[6]) f6 = 1'b0;
      if (v[5]) f5 = 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      summarize;
   end

   initial begin
      reset = 1'b1;
      bus_req = '0;
      power_save = 1'b0;
      rx_frame_done = 1'b0;
      rx_dest_addr_bit0 = 1'b0;
      wake_frame_event = 1'b0;
      wake_packet_event = 1'b0;
      {en9, en2, en1, f6, f5} = '0;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      rd(WAKE_OFS, q);
      chk("wake_reset", 32'h0, q);
      rd(OFFLOAD_OFS, q);
      chk("offload_reset", 32'h0, q);
      for (int i = 0; i < 8; i++) begin
         rd(FILTER_OFS, q);
         chk("filter_reset", 32'h0, q);
      end
      // nine writes: the last one must land on word zero again
      for (int i = 0; i < 9; i++) begin
         d = $random(seed);
         wr(FILTER_OFS, d);
         fw[i % 8] = d;
      end
      for (int i = 0; i < 8; i++) begin
         chk("filter_word", fw[i], filter_words[i]);
      end
      for (int i = 0; i < 9; i++) begin
         rd(FILTER_OFS, q);
         chk("filter_read", fw[i % 8], q);
      end
      // partial run, then reset: both pointers must restart at word zero
      for (int i = 0; i < 3; i++) wr(FILTER_OFS, 32'h0);
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      d = $random(seed);
      wr(FILTER_OFS, d);
      chk("filter_word_after_reset", d, filter_words[0]);
      rd(FILTER_OFS, q);
      chk("filter_read_after_reset", d, q);
      for (int i = 0; i < 8; i++) begin
         d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $random(seed);
         wr(OFFLOAD_OFS, d); // all ones first, then zero, then random words
         q = {29'h0, offload_ctrl};
         chk("offload_ctrl", {29'h0, d[16], d[1], d[0]}, q);
         rd(OFFLOAD_OFS, q);
         chk("offload_read", d & 32'h0001_0003, q);
      end
      wake_write(32'hffff_ffff);
      for (int k = 0; k < 4; k++) ev(k, 1'b1);
      for (int n = 0; n < 60; n++) begin
         if ($random(seed) & 1) wake_write($random(seed));
         else ev($random(seed) & 3, 1'($random(seed)));
         rd(WAKE_OFS, q);
         chk("wake_read", wake_exp(), q);
         chk("wake_ctrl", {29'h0, en9, en2, en1}, {29'h0, wake_ctrl});
      end
      // event and clearing write in one cycle: the set must win
      wake_write(32'h0000_0006);
      @(posedge ref_clk);
      bus_req.addr <= WAKE_OFS;
      bus_req.wdata <= 32'h0000_0066;
      bus_req.wr <= 1'b1;
      wake_frame_event <= 1'b1;
      wake_packet_event <= 1'b1;
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
      wake_frame_event <= 1'b0;
      wake_packet_event <= 1'b0;
      {f6, f5} = 2'b11;
      rd(WAKE_OFS, q);
      chk("wake_set_wins", wake_exp(), q);
      for (int i = 0; i < 32; i++) begin
         pv[i] = 16'($random(seed));
         if (i == 0) pv[i][15] = 1'b0;
         phy_wr(i, pv[i]);
      end
      for (int i = 0; i < 32; i++) begin
         phy_rd(i, q);
         chk("phy_reg", phy_mapped(i) ? {16'h0, pv[i]} : 32'h0, q);
      end
      chk("phy_control", {16'h0, pv[0]}, {16'h0, phy_control});
      phy_wr(0, 16'h8000);
      chk("soft_reset_pulse", 32'h1, {31'h0, phy_soft_reset});
      @(negedge ref_clk);
      chk("soft_reset_end", 32'h0, {31'h0, phy_soft_reset});
      chk("phy_control_soft", {16'h0, PHY_BCR_RST}, {16'h0, phy_control});
      phy_rd(18, q);
      chk("phy_kept", {16'h0, pv[18]}, {16'h0, q[15:0]});
      phy_rd(4, q);
      chk("phy_cleared", 32'h0, {16'h0, q[15:0]});
      rd(MGMT_ACCESS_OFS, q);
      chk("mgmt_access", 32'h0000_0100, q);
      wr(8'hbc, $random(seed));
      rd(8'hbc, q);
      chk("unmapped_read", 32'h0, q);
      summarize;
   end
endmodule
